// ==== rtl/dsb_top.sv ====
// decimal string to binary execution unit with apb access to its accumulators
// assumes memory on clk_i answering reads with a one-cycle ack; irq pin is asynchronous
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// Function
// - start from the result pair when significance is set, else from zero
// - offset variant sets significance at once; table variant leaves it to the table
// - bytes taken left first; offset digit is byte plus signed operand half
// - table word at operand plus half the byte; even left half, odd right
// - half-word holds three-bit function code on top and four-bit digit below
// - codes 0,2,3 substitute only with significance; 2 clears minus, 3 sets it
// - code 1 ends without flag change; code 5 sets nonzero then ends
// - codes 4,6,7 set significance and nonzero and substitute; 6 clears, 7 sets minus
// - on end or digit above nine keep count and partial result, no skip
// - each accepted digit: value times ten plus digit, then next byte
// - no overflow check; high-order bits silently lost
// - after all bytes negate if minus, store result, skip next instruction
// - pointer left on last byte read; count shows unprocessed bytes; string untouched
// - table address is base plus byte without its low bit
// - interrupt stops between bytes with count and partial result saved
// - a preset base is multiplied by ten before the first digit
// - nonzero flag never steers; minus may be preset by software
// - five accumulators: flags and length, pointer, spare, result pair
// - the instruction word must carry extended opcode 123 octal
// - result is two's complement, high word bit 0 sign, low sign copy unused
module dsb_top (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic mem_req_o,
    output logic [17:0] mem_addr_o,
    input wire logic [35:0] mem_rdata_i,
    input wire logic mem_ack_i,
    input wire logic irq_req_i,
    output logic busy_o,
    output logic done_o,
    output logic skip_o
);
    dsb_pkg::dsb_state_e state_reg;
    logic [35:0] acc_reg [5];
    logic [17:0] opnd_reg;
    logic table_reg;
    logic skip_reg;
    logic intr_reg;
    logic badop_reg;
    logic [35:0] byte_reg;
    logic irq_q1;
    logic irq_q2;
    logic wr_en;
    logic start_cmd;
    logic [31:0] rd_mux;
    logic mapped;
    logic [26:0] len;
    logic [5:0] bp_pos;
    logic [5:0] bp_size;
    logic [35:0] ptr_next;
    logic [35:0] byte_val;
    logic [36:0] off_sum;
    logic off_ok;
    logic [17:0] tab_addr;
    logic [17:0] t_half;
    logic [2:0] t_code;
    logic [3:0] t_digit;
    logic [3:0] digit_mux;
    logic s_next;
    logic n_next;
    logic m_next;
    logic t_accept;
    logic t_term;
    logic [70:0] cur_val;
    logic [70:0] mac_val;
    logic [70:0] neg_val;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    // irq pin synchroniser
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            irq_q1 <= 1'b0;
            irq_q2 <= 1'b0;
        end
        else
        begin
            irq_q1 <= irq_req_i;
            irq_q2 <= irq_q1;
        end
    end

    // apb decode
    assign wr_en = psel_i && penable_i && pwrite_i && pready_o;
    assign start_cmd = wr_en && (paddr_i == dsb_pkg::ADDR_INSTR) && (state_reg == dsb_pkg::ST_IDLE)
        && (pwdata_i[8:0] == dsb_pkg::EXT_OPCODE);
    assign mapped = (paddr_i[1:0] == 2'h0) && ((paddr_i < dsb_pkg::ADDR_ACC_END)
        || (paddr_i == dsb_pkg::ADDR_INSTR) || (paddr_i == dsb_pkg::ADDR_OPND)
        || (paddr_i == dsb_pkg::ADDR_STATUS));

    // read data mux
    always_comb
    begin
        rd_mux = 32'h00000000;
        if (paddr_i < dsb_pkg::ADDR_ACC_END)
        begin
            if (paddr_i[2])
                rd_mux = {28'h0000000, acc_reg[paddr_i[5:3]][35:32]};
            else
                rd_mux = acc_reg[paddr_i[5:3]][31:0];
        end
        else if (paddr_i == dsb_pkg::ADDR_INSTR)
            rd_mux = {22'h000000, table_reg, dsb_pkg::EXT_OPCODE};
        else if (paddr_i == dsb_pkg::ADDR_OPND)
            rd_mux = {14'h0000, opnd_reg};
        else if (paddr_i == dsb_pkg::ADDR_STATUS)
            rd_mux = {28'h0000000, badop_reg, intr_reg, skip_reg, busy_o};
    end

    // apb answer registered in the setup cycle
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end
        else
        begin
            pready_o <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !mapped;
            prdata_o <= rd_mux;
        end
    end

    // byte pointer advance: step right by one byte, wrap to next word
    assign len = acc_reg[0][dsb_pkg::LEN_MSB:0];
    assign bp_pos = acc_reg[1][dsb_pkg::PTR_POS_LSB +: 6];
    assign bp_size = acc_reg[1][dsb_pkg::PTR_SIZE_LSB +: 6];
    always_comb
    begin
        ptr_next = acc_reg[1];
        if (bp_pos >= bp_size)
            ptr_next[dsb_pkg::PTR_POS_LSB +: 6] = bp_pos - bp_size;
        else
        begin
            ptr_next[dsb_pkg::PTR_POS_LSB +: 6] = dsb_pkg::WORD_BITS - bp_size;
            ptr_next[dsb_pkg::PTR_ADDR_MSB:0] = acc_reg[1][dsb_pkg::PTR_ADDR_MSB:0] + 18'h00001;
        end
    end

    // byte extraction and offset digit
    assign byte_val = (mem_rdata_i >> bp_pos) & ~(36'hFFFFFFFFF << bp_size);
    assign off_sum = {1'b0, byte_val}
        + {{19{opnd_reg[dsb_pkg::OFFSET_SIGN_BIT]}}, opnd_reg};
    assign off_ok = !off_sum[36] && (off_sum[35:0] <= {32'h00000000, dsb_pkg::MAX_DIGIT});
    assign tab_addr = opnd_reg + byte_val[18:1];

    // translation entry decode: even byte left half, odd byte right half
    assign t_half = byte_reg[0] ? mem_rdata_i[17:0] : mem_rdata_i[35:18];
    assign t_code = t_half[dsb_pkg::TAB_CODE_LSB +: 3];
    assign t_digit = t_half[3:0];

    // translation function flag effects; nonzero is only recorded
    always_comb
    begin
        s_next = acc_reg[0][dsb_pkg::FLAG_S_BIT];
        n_next = acc_reg[0][dsb_pkg::FLAG_N_BIT];
        m_next = acc_reg[0][dsb_pkg::FLAG_M_BIT];
        t_accept = 1'b0;
        t_term = 1'b0;
        case (t_code)
            dsb_pkg::FN_SUB: t_accept = s_next;
            dsb_pkg::FN_SUB_PLUS:
            begin
                m_next = 1'b0;
                t_accept = s_next;
            end
            dsb_pkg::FN_SUB_MINUS:
            begin
                m_next = 1'b1;
                t_accept = s_next;
            end
            dsb_pkg::FN_STOP: t_term = 1'b1;
            dsb_pkg::FN_STOP_N:
            begin
                n_next = 1'b1;
                t_term = 1'b1;
            end
            default:
            begin
                s_next = 1'b1;
                n_next = 1'b1;
                t_accept = 1'b1;
                if (t_code == dsb_pkg::FN_SIG_PLUS)
                    m_next = 1'b0;
                else if (t_code == dsb_pkg::FN_SIG_MINUS)
                    m_next = 1'b1;
            end
        endcase
    end

    // running value: high word whole, low word without its sign copy
    assign cur_val = {acc_reg[3], acc_reg[4][34:0]};
    assign neg_val = ~cur_val + 71'h1;
    assign digit_mux = table_reg ? t_digit : off_sum[3:0];

    dsb_mul10_add u_mac (
        .val_i(cur_val),
        .digit_i(digit_mux),
        .res_o(mac_val)
    );

    // conversion engine and software-visible state
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state_reg <= dsb_pkg::ST_IDLE;
            for (int i = 0; i < 5; i++)
                acc_reg[i] <= dsb_pkg::ACC_RST;
            opnd_reg <= dsb_pkg::OPND_RST;
            table_reg <= 1'b0;
            skip_reg <= 1'b0;
            intr_reg <= 1'b0;
            badop_reg <= 1'b0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            mem_req_o <= 1'b0;
            mem_addr_o <= 18'h00000;
            byte_reg <= 36'h000000000;
        end
        else
        begin
            done_o <= 1'b0;
            case (state_reg)
                dsb_pkg::ST_IDLE:
                begin
                    if (wr_en && paddr_i < dsb_pkg::ADDR_ACC_END)
                    begin
                        if (paddr_i[2])
                            acc_reg[paddr_i[5:3]][35:32] <= pwdata_i[3:0];
                        else
                            acc_reg[paddr_i[5:3]][31:0] <= pwdata_i;
                    end
                    if (wr_en && paddr_i == dsb_pkg::ADDR_OPND)
                        opnd_reg <= pwdata_i[17:0];
                    if (wr_en && paddr_i == dsb_pkg::ADDR_INSTR)
                        badop_reg <= !start_cmd;
                    if (start_cmd)
                    begin
                        table_reg <= pwdata_i[dsb_pkg::INSTR_TABLE_BIT];
                        busy_o <= 1'b1;
                        skip_reg <= 1'b0;
                        intr_reg <= 1'b0;
                        if (!acc_reg[0][dsb_pkg::FLAG_S_BIT])
                        begin
                            acc_reg[3] <= dsb_pkg::ACC_RST;
                            acc_reg[4] <= dsb_pkg::ACC_RST;
                        end
                        if (!pwdata_i[dsb_pkg::INSTR_TABLE_BIT])
                            acc_reg[0][dsb_pkg::FLAG_S_BIT] <= 1'b1;
                        state_reg <= dsb_pkg::ST_STEP;
                    end
                end
                dsb_pkg::ST_STEP:
                begin
                    if (len == 27'h0)
                        state_reg <= dsb_pkg::ST_FINISH;
                    else if (irq_q2)
                    begin
                        intr_reg <= 1'b1;
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                        state_reg <= dsb_pkg::ST_IDLE;
                    end
                    else
                    begin
                        acc_reg[1] <= ptr_next;
                        mem_addr_o <= ptr_next[dsb_pkg::PTR_ADDR_MSB:0];
                        mem_req_o <= 1'b1;
                        state_reg <= dsb_pkg::ST_RDBYTE;
                    end
                end
                dsb_pkg::ST_RDBYTE:
                begin
                    if (mem_ack_i)
                    begin
                        mem_req_o <= 1'b0;
                        acc_reg[0][dsb_pkg::LEN_MSB:0] <= len - 27'h1;
                        if (table_reg)
                        begin
                            byte_reg <= byte_val;
                            mem_addr_o <= tab_addr;
                            mem_req_o <= 1'b1;
                            state_reg <= dsb_pkg::ST_RDTAB;
                        end
                        else if (off_ok)
                        begin
                            acc_reg[3] <= mac_val[70:35];
                            acc_reg[4] <= {mac_val[70], mac_val[34:0]};
                            state_reg <= dsb_pkg::ST_STEP;
                        end
                        else
                        begin
                            busy_o <= 1'b0;
                            done_o <= 1'b1;
                            state_reg <= dsb_pkg::ST_IDLE;
                        end
                    end
                end
                dsb_pkg::ST_RDTAB:
                begin
                    if (mem_ack_i)
                    begin
                        mem_req_o <= 1'b0;
                        acc_reg[0][35:33] <= {s_next, n_next, m_next};
                        if (t_term || (t_accept && t_digit > dsb_pkg::MAX_DIGIT))
                        begin
                            busy_o <= 1'b0;
                            done_o <= 1'b1;
                            state_reg <= dsb_pkg::ST_IDLE;
                        end
                        else
                        begin
                            if (t_accept)
                            begin
                                acc_reg[3] <= mac_val[70:35];
                                acc_reg[4] <= {mac_val[70], mac_val[34:0]};
                            end
                            state_reg <= dsb_pkg::ST_STEP;
                        end
                    end
                end
                dsb_pkg::ST_FINISH:
                begin
                    if (acc_reg[0][dsb_pkg::FLAG_M_BIT])
                    begin
                        acc_reg[3] <= neg_val[70:35];
                        acc_reg[4] <= {neg_val[70], neg_val[34:0]};
                    end
                    else
                        acc_reg[4][35] <= acc_reg[3][35];
                    skip_reg <= 1'b1;
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                    state_reg <= dsb_pkg::ST_IDLE;
                end
                default:
                    state_reg <= dsb_pkg::ST_IDLE;
            endcase
        end
    end

    assign skip_o = skip_reg;

    // checks on the conversion engine
    property p_off_sets_s;
        start_cmd && !pwdata_i[dsb_pkg::INSTR_TABLE_BIT] |=> acc_reg[0][dsb_pkg::FLAG_S_BIT];
    endproperty
    a_off_sets_s: assert property (p_off_sets_s) else $error("offset start left s clear");

    property p_base_zero;
        start_cmd && !acc_reg[0][dsb_pkg::FLAG_S_BIT] |=> (acc_reg[3] == 36'h0) && (acc_reg[4] == 36'h0);
    endproperty
    a_base_zero: assert property (p_base_zero) else $error("zero base not applied");

    property p_tab_addr;
        state_reg == dsb_pkg::ST_RDBYTE && mem_ack_i && table_reg
            |=> mem_req_o && mem_addr_o == opnd_reg + byte_reg[18:1];
    endproperty
    a_tab_addr: assert property (p_tab_addr) else $error("table address wrong");

    property p_len_dec;
        state_reg == dsb_pkg::ST_RDBYTE && mem_ack_i |=> len == $past(len) - 27'h1;
    endproperty
    a_len_dec: assert property (p_len_dec) else $error("count not decremented");

    property p_skip_len;
        $rose(skip_reg) |-> len == 27'h0 && done_o;
    endproperty
    a_skip_len: assert property (p_skip_len) else $error("skip with bytes left");

    property p_stop_keep;
        state_reg == dsb_pkg::ST_RDTAB && mem_ack_i && t_code == dsb_pkg::FN_STOP
            |=> acc_reg[0][35:33] == $past(acc_reg[0][35:33]) && done_o && !skip_reg;
    endproperty
    a_stop_keep: assert property (p_stop_keep) else $error("stop code changed flags");

    property p_bad_digit;
        state_reg == dsb_pkg::ST_RDBYTE && mem_ack_i && !table_reg && !off_ok
            |=> done_o && !skip_reg && cur_val == $past(cur_val);
    endproperty
    a_bad_digit: assert property (p_bad_digit) else $error("bad digit not handled");

    property p_req_hold;
        mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("memory request dropped");

    property p_negate;
        state_reg == dsb_pkg::ST_FINISH && acc_reg[0][dsb_pkg::FLAG_M_BIT]
            |=> cur_val == ~$past(cur_val) + 71'h1;
    endproperty
    a_negate: assert property (p_negate) else $error("minus result not negated");

    property p_mul10;
        state_reg == dsb_pkg::ST_RDBYTE && mem_ack_i && !table_reg && off_ok
            |=> cur_val == $past(cur_val) * 71'h0A + {67'h0, $past(off_sum[3:0])};
    endproperty
    a_mul10: assert property (p_mul10) else $error("accumulate wrong");
endmodule
`default_nettype wire

// ==== rtl/dsb_pkg.sv ====
// package of constants for the decimal string to binary converter
// assumes 36-bit words with bit 0 the most significant; sv bit = 35 - word bit
package dsb_pkg;

    // apb byte offsets
    localparam logic [7:0] ADDR_ACC_END = 8'h28; // accumulators at 8*i (low) and 8*i+4 (high)
    localparam logic [7:0] ADDR_INSTR = 8'h28;
    localparam logic [7:0] ADDR_OPND = 8'h2C;
    localparam logic [7:0] ADDR_STATUS = 8'h30;

    // instruction register fields
    localparam logic [8:0] EXT_OPCODE = 9'h053; // 123 octal
    localparam int INSTR_TABLE_BIT = 9;

    // first accumulator fields
    localparam int FLAG_S_BIT = 35;
    localparam int FLAG_N_BIT = 34;
    localparam int FLAG_M_BIT = 33;
    localparam int LEN_MSB = 26;

    // byte pointer fields in the second accumulator
    localparam int PTR_POS_LSB = 30;
    localparam int PTR_SIZE_LSB = 24;
    localparam int PTR_ADDR_MSB = 17;
    localparam logic [5:0] WORD_BITS = 6'h24;

    // translation half-word fields
    localparam int TAB_CODE_LSB = 15;
    localparam int OFFSET_SIGN_BIT = 17;
    localparam logic [3:0] MAX_DIGIT = 4'h9;

    // translation function codes
    localparam logic [2:0] FN_SUB = 3'h0;
    localparam logic [2:0] FN_STOP = 3'h1;
    localparam logic [2:0] FN_SUB_PLUS = 3'h2;
    localparam logic [2:0] FN_SUB_MINUS = 3'h3;
    localparam logic [2:0] FN_SIG = 3'h4;
    localparam logic [2:0] FN_STOP_N = 3'h5;
    localparam logic [2:0] FN_SIG_PLUS = 3'h6;
    localparam logic [2:0] FN_SIG_MINUS = 3'h7;

    // reset values
    localparam logic [35:0] ACC_RST = 36'h000000000;
    localparam logic [17:0] OPND_RST = 18'h00000;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_STEP = 5'h02,
        ST_RDBYTE = 5'h04,
        ST_RDTAB = 5'h08,
        ST_FINISH = 5'h10
    } dsb_state_e;

endpackage

// ==== rtl/dsb_mul10_add.sv ====
// multiply a 71-bit twos complement value by ten and add a digit
// assumes the caller accepts silent loss of the high-order part
`timescale 1ns/10ps
`default_nettype none
module dsb_mul10_add (
    input wire logic [70:0] val_i,
    input wire logic [3:0] digit_i,
    output logic [70:0] res_o
);
    // eight times plus two times plus digit, wrapped to 71 bits
    assign res_o = (val_i << 3) + (val_i << 1) + {67'h0, digit_i};
endmodule
`default_nettype wire

// ==== verif/dsb_mem_model.sv ====
// memory model: string words and translation table for the converter
// assumes requests are held until ack; answer delay set by lat_i
`timescale 1ns/10ps
`default_nettype none
module dsb_mem_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mem_req_i,
    input wire logic [17:0] mem_addr_i,
    input wire logic [3:0] lat_i,
    output logic [35:0] mem_rdata_o,
    output logic mem_ack_o
);
    logic [35:0] mem [0:63];
    logic [3:0] wait_cnt;

    // string words (9-bit bytes) and table entries at base 16
    initial
    begin
        for (int i = 0; i < 64; i++)
            mem[i] = 36'h0;
        mem[0] = {9'h031, 9'h032, 9'h033, 9'h03B};
        mem[1] = {9'h034, 9'h035, 18'h0};
        mem[2] = {9'h020, 9'h02D, 9'h037, 9'h03B};
        mem[3] = {9'h034, 9'h030, 9'h033, 9'h035};
        for (int i = 4; i < 11; i++)
            mem[i] = {4{9'h031}};
        mem[32] = {3'h0, 11'h0, 4'h5, 18'h0}; // space: code 0
        mem[38] = {18'h0, 3'h3, 11'h0, 4'h6}; // minus: code 3
        mem[40] = {3'h6, 11'h0, 4'h0, 18'h0};
        mem[41] = {18'h0, 3'h2, 11'h0, 4'h3};
        mem[42] = {3'h7, 11'h0, 4'h4, 3'h5, 11'h0, 4'h9};
        mem[43] = {18'h0, 3'h4, 11'h0, 4'h7};
        mem[45] = {18'h0, 3'h1, 11'h0, 4'h8}; // semicolon: code 1
    end

    // answer a held read after lat_i cycles; data toggles when not answering
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mem_ack_o <= 1'b0;
            mem_rdata_o <= 36'h0;
            wait_cnt <= 4'h0;
        end
        else if (mem_ack_o)
        begin
            mem_ack_o <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o;
            wait_cnt <= 4'h0;
        end
        else if (mem_req_i && wait_cnt >= lat_i)
        begin
            mem_ack_o <= 1'b1;
            mem_rdata_o <= mem[mem_addr_i[5:0]]; // read only
        end
        else
        begin
            mem_rdata_o <= ~mem_rdata_o;
            wait_cnt <= mem_req_i ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

// ==== verif/test_dsb_top.sv ====
// self-checking bench for the decimal string to binary unit
// assumes dsb_pkg, dsb_top and dsb_mem_model compiled before it
`timescale 1ns/10ps
`default_nettype none
`define CHK(name, exp, got) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("ERROR %s expected %h seen %h", name, exp, got); \
        end \
    end
module test_dsb_top;
    logic clk_i, srst_i, psel, penable, pwrite, irq_req, mem_req, mem_ack;
    logic pready, pslverr, busy, done, skip, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [17:0] mem_addr;
    logic [35:0] mem_rdata, v;
    logic [3:0] lat;
    int n_checks = 0;
    int mismatches = 0;

    dsb_top u_dsb_top (
        .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .mem_req_o(mem_req),
        .mem_addr_o(mem_addr), .mem_rdata_i(mem_rdata), .mem_ack_i(mem_ack),
        .irq_req_i(irq_req), .busy_o(busy), .done_o(done), .skip_o(skip)
    );
    dsb_mem_model u_dsb_mem_model (
        .clk_i(clk_i), .rst_i(srst_i), .mem_req_i(mem_req), .mem_addr_i(mem_addr),
        .lat_i(lat), .mem_rdata_o(mem_rdata), .mem_ack_o(mem_ack)
    );

    // 50 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // apb transfer: setup, access, hold until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1)
            @(posedge clk_i);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic acc_wr(input logic [4:0] i, input logic [35:0] d);
        apb(1'b1, {i, 3'h0}, d[31:0], rd, err);
        apb(1'b1, {i, 3'h4}, {28'h0, d[35:32]}, rd, err);
    endtask

    task automatic acc_rd(input logic [4:0] i, output logic [35:0] d);
        logic [31:0] hi;
        apb(1'b0, {i, 3'h0}, 32'h0, rd, err);
        apb(1'b0, {i, 3'h4}, 32'h0, hi, err);
        d = {hi[3:0], rd};
    endtask

    task automatic start(input logic tab);
        apb(1'b1, 8'h28, {22'h0, tab, 9'h053}, rd, err);
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while (done !== 1'b1 && n < 2000)
        begin
            @(posedge clk_i);
            n++;
        end
        `CHK("done", 1'b1, done)
    endtask

    task automatic chk_res(input logic [70:0] e);
        logic [35:0] hi;
        acc_rd(5'h3, hi);
        acc_rd(5'h4, v);
        `CHK("result", e, {hi, v[34:0]})
    endtask

    function automatic logic [35:0] ptr(input logic [5:0] p, input logic [17:0] a);
        return {p, 6'h09, 6'h00, a};
    endfunction

    // value of k ones digits, wrapped to 71 bits
    function automatic logic [70:0] ones(input int k);
        logic [70:0] r;
        r = 71'h0;
        for (int j = 0; j < k; j++)
            r = r * 71'hA + 71'h1;
        return r;
    endfunction

    // load accumulators and operand, run, compare block and skip
    task automatic conv(input logic tab, input logic [35:0] a0, a1, input logic [17:0] op,
                        input logic [35:0] e0, e1, input logic [70:0] e, input logic es);
        acc_wr(5'h0, a0);
        acc_wr(5'h1, a1);
        apb(1'b1, 8'h2C, {14'h0, op}, rd, err);
        start(tab);
        wait_done();
        acc_rd(5'h0, v);
        `CHK("acc0", e0, v)
        acc_rd(5'h1, v);
        `CHK("pointer", e1, v)
        chk_res(e);
        `CHK("skip", es, skip)
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        stop_test();
    end

    // main sequence
    initial
    begin
        srst_i = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        irq_req = 1'b0;
        lat = 4'h0;
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            acc_rd(5'(i), v);
            `CHK("acc reset", 36'h0, v)
        end
        apb(1'b0, 8'h34, 32'h0, rd, err);
        `CHK("unmapped err", 1'b1, err)
        apb(1'b1, 8'h28, 32'h052, rd, err);
        apb(1'b0, 8'h30, 32'h0, rd, err);
        `CHK("status", 32'h8, rd)
        acc_wr(5'h3, 36'h5);
        conv(0, 36'h6, ptr(6'h24, 0), 18'h3FFD0, 36'h800000002, ptr(6'h00, 0), 71'h7B, 0);
        conv(0, 36'h800000002, ptr(6'h24, 1), 18'h3FFD0, 36'h800000000, ptr(6'h12, 1),
             71'h3039, 1);
        conv(0, 36'h200000003, ptr(6'h24, 0), 18'h3FFD0, 36'hA00000000, ptr(6'h09, 0),
             -71'h7B, 1);
        conv(1, 36'h5, ptr(6'h24, 2), 18'h10, 36'hE00000001, ptr(6'h00, 2), 71'h7, 0);
        conv(1, 36'h200000004, ptr(6'h24, 3), 18'h10, 36'hC00000000, ptr(6'h00, 3),
             71'h193, 0);
        // interrupt mid-string, then resume to a wrapped 25-digit value
        acc_wr(5'h0, 36'h19);
        acc_wr(5'h1, ptr(6'h24, 4));
        // the table runs left the operand at the table base; restore the ascii offset
        apb(1'b1, 8'h2C, {14'h0, 18'h3FFD0}, rd, err);
        lat <= 4'h3;
        start(0);
        apb(1'b0, 8'h30, 32'h0, rd, err);
        `CHK("busy status", 1'b1, rd[0])
        `CHK("busy pin", 1'b1, busy)
        repeat (27) @(posedge clk_i);
        irq_req <= 1'b1;
        wait_done();
        irq_req <= 1'b0;
        apb(1'b0, 8'h30, 32'h0, rd, err);
        `CHK("interrupted", 1'b1, rd[2])
        `CHK("skip irq", 1'b0, skip)
        acc_rd(5'h0, v);
        chk_res(ones(25 - int'(v[26:0])));
        start(0);
        wait_done();
        chk_res(ones(25));
        acc_rd(5'h1, v);
        `CHK("pointer end", ptr(6'h1B, 10), v)
        `CHK("skip end", 1'b1, skip)
        stop_test();
    end
endmodule
`default_nettype wire
